//--- pkg/ast_cfg.svh
// Purpose: constants for the asynchronous serial transceiver
// Assumes: 250 MHz system clock
// Notes: included by bare name
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_OVS 16
`define AST_OVS_MID 8
`define AST_OVS_W 4
`define AST_BRG_W 16
`define AST_BRG_RST 16'h00A1
`define AST_CLK_NS 4
`define AST_TCY_NS 4
`define AST_TCY_CYC ((`AST_TCY_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
`define AST_FIFO_DEPTH 2
`endif

//--- pkg/ast_pkg.sv
// Purpose: types for the asynchronous serial transceiver
// Assumes: nothing
// Notes: constants live in ast_cfg.svh
package ast_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;
endpackage

//--- test/ast_remote_node.sv
// Purpose: remote serial node on the far side of both serial lines
// Assumes: bit period is a whole number of system clocks, set in bit_clks
// Notes: behavioural; sends and frame-checks characters on request
`timescale 1ns/1ps
module ast_remote_node (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic line_in,
   input wire logic tap_in,
   output logic line_out
);
   int bit_clks = 32;

   // Line rests at mark between characters
   initial line_out = 1'b1;

   // One character out; stop_lvl 0 fakes a broken stop bit
   task automatic send(input logic [8:0] d, input int nb, input logic stop_lvl);
      @(negedge clk);
      line_out = 1'b0;
      repeat (bit_clks) @(negedge clk);
      for (int i = 0; i < nb; i++) begin
         line_out = d[i];
         repeat (bit_clks) @(negedge clk);
      end
      line_out = stop_lvl;
      repeat (bit_clks) @(negedge clk);
      line_out = 1'b1;
      repeat (bit_clks) @(negedge clk);
   endtask

   // Frame-checks one character; each bit sampled at a quarter and three quarters
   task automatic recv(input int nb, output logic [8:0] d, output logic ok);
      logic a;
      logic b;
      int n;
      d = 9'h000;
      ok = 1'b0;
      n = 0;
      while (line_in !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 4000) return;
      ok = 1'b1;
      for (int i = 0; i < nb + 2; i++) begin
         repeat (bit_clks / 4) @(posedge clk);
         a = line_in;
         repeat (bit_clks / 2) @(posedge clk);
         b = line_in;
         if (a !== b || tap_in !== b) ok = 1'b0;
         if (i == 0 && b !== 1'b0) ok = 1'b0;
         else if (i == nb + 1 && b !== 1'b1) ok = 1'b0;
         else if (i > 0 && i <= nb) d[i-1] = b;
         // Stop short in the stop bit so a 1-clock gap is not missed
         if (i < nb + 1) repeat (bit_clks / 4) @(posedge clk);
      end
   endtask
endmodule // ast_remote_node

//--- test/tb_async_serial_transceiver.sv
// Purpose: self-checking bench for the serial transceiver
// Assumes: brg_div 1 gives 32 clocks per bit
// Notes: remote node model sits on both serial lines
`timescale 1ns/1ps
module tb_async_serial_transceiver;
   // Stimulus and observation
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic port_en = 1'b1, tx_en = 1'b0, rx_en = 1'b1, nine_bit = 1'b0, brg_16 = 1'b0, addr_detect = 1'b0;
   logic [15:0] brg_div = 16'h0001;
   logic tx_wr = 1'b0, rx_rd = 1'b0, ovr_clr = 1'b0;
   logic [8:0] tx_wdata = 9'h000;
   logic rx_pin, tx_pin, tx_tap, tbe, tx_idle, frame_err, avail, overrun;
   logic [8:0] rx_data;
   int n_mismatch = 0;
   int n_tests = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   ast_uart u_dut (.clk(clk), .rst_n(rst_n), .port_en(port_en), .tx_en(tx_en), .rx_en(rx_en),
      .nine_bit(nine_bit), .brg_16(brg_16), .brg_div(brg_div), .addr_detect(addr_detect), .tx_wr(tx_wr),
      .tx_wdata(tx_wdata), .rx_rd(rx_rd), .ovr_clr(ovr_clr), .rx_pin(rx_pin), .tx_or_clock_pin(tx_pin),
      .tx_to_logic_cell(tx_tap), .tx_buffer_empty_flag(tbe), .tx_shift_empty(tx_idle),
      .rx_data_reg(rx_data), .rx_frame_err(frame_err), .rx_avail(avail), .rx_overrun(overrun));

   ast_remote_node u_node (.clk(clk), .line_in(tx_pin), .tap_in(tx_tap), .line_out(rx_pin));

   // Verdict and end of run
   task automatic conclude();
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Compares one observed value and counts it
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait on tbe (0), rx_avail (1) or shifter idle (2)
   task automatic wait_hi(input int which);
      int n;
      n = 0;
      while (n < 20000 && ((which == 0) ? tbe : (which == 1) ? avail : tx_idle) !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         n_mismatch++;
         $display("Error wait %0d expected 1 seen 0", which);
         conclude();
      end
   endtask

   // One-cycle pulses for write and pop
   task automatic tx_write(input logic [8:0] d);
      @(negedge clk);
      tx_wr = 1'b1;
      tx_wdata = d;
      @(negedge clk);
      tx_wr = 1'b0;
   endtask

   task automatic pop();
      @(negedge clk);
      rx_rd = 1'b1;
      @(negedge clk);
      rx_rd = 1'b0;
      @(negedge clk);
   endtask

   // Idle levels out of reset, then flag follows enable
   task automatic t_reset();
      check("tx line", 9'h001, {8'h00, tx_pin});
      check("tbe off", 9'h000, {8'h00, tbe});
      check("shifter idle", 9'h001, {8'h00, tx_idle});
      check("rx empty", 9'h000, {8'h00, avail});
      tx_en = 1'b1;
      repeat (3) @(negedge clk);
      check("tbe on", 9'h001, {8'h00, tbe});
      check("tap idle", 9'h001, {8'h00, tx_tap});
      // Baud counter first runs down from its reset divisor; a frame started then has a long start bit
      repeat (170) @(negedge clk);
   endtask

   // Single character out, frame-checked by the remote node
   task automatic t_tx(input logic nine, input logic [8:0] d);
      logic [8:0] got;
      logic ok;
      @(negedge clk);
      nine_bit = nine;
      wait_hi(0);
      tx_write(d);
      u_node.recv(nine ? 9 : 8, got, ok);
      check("tx frame", 9'h001, {8'h00, ok});
      check("tx data", nine ? d : {1'b0, d[7:0]}, got);
      wait_hi(2);
   endtask

   // Second write queues behind a busy shifter
   task automatic t_b2b();
      logic [8:0] g1, g2;
      logic k1, k2;
      @(negedge clk);
      nine_bit = 1'b0;
      fork
         begin
            u_node.recv(8, g1, k1);
            u_node.recv(8, g2, k2);
         end
         begin
            tx_write(9'h0F0);
            repeat (4) @(negedge clk);
            wait_hi(0);
            tx_write(9'h033);
            repeat (2) @(negedge clk);
            check("tbe queued", 9'h000, {8'h00, tbe});
         end
      join
      check("b2b frames", 9'h001, {8'h00, k1 & k2});
      check("b2b first", 9'h0F0, g1);
      check("b2b second", 9'h033, g2);
      wait_hi(2);
      check("tbe drained", 9'h001, {8'h00, tbe});
   endtask

   // Remote node sends; storage, data and stop status judged
   task automatic t_rx(input logic nine, input logic addr, input logic [8:0] d, input logic stop, input logic kept);
      @(negedge clk);
      nine_bit = nine;
      addr_detect = addr;
      u_node.send(d, nine ? 9 : 8, stop);
      check("rx stored", {8'h00, kept}, {8'h00, avail});
      if (kept) begin
         check("rx data", nine ? d : {1'b0, d[7:0]}, rx_data);
         check("rx frame err", {8'h00, ~stop}, {8'h00, frame_err});
         pop();
      end
   endtask

   // Three characters into a two-entry FIFO
   task automatic t_overrun();
      t_rx(1'b0, 1'b0, 9'h000, 1'b1, 1'b1);
      u_node.send(9'h011, 8, 1'b1);
      u_node.send(9'h022, 8, 1'b1);
      check("overrun early", 9'h000, {8'h00, overrun});
      u_node.send(9'h044, 8, 1'b1);
      check("overrun", 9'h001, {8'h00, overrun});
      check("fifo head", 9'h011, rx_data);
      pop();
      check("fifo second", 9'h022, rx_data);
      pop();
      check("fifo drained", 9'h000, {8'h00, avail});
      @(negedge clk);
      ovr_clr = 1'b1;
      @(negedge clk);
      ovr_clr = 1'b0;
      @(negedge clk);
      check("overrun cleared", 9'h000, {8'h00, overrun});
   endtask

   // Divider modes; both directions at once on the shared rate
   task automatic t_rate();
      @(negedge clk);
      brg_div = 16'hFF01; // Upper byte must be ignored in 8-bit mode
      t_tx(1'b0, 9'h0C3);
      @(negedge clk);
      brg_16 = 1'b1;
      brg_div = 16'h0003;
      u_node.bit_clks = 64;
      fork
         t_tx(1'b1, 9'h13C);
         begin
            repeat (40) @(negedge clk);
            t_rx(1'b1, 1'b0, 9'h0A6, 1'b1, 1'b1);
         end
      join
   endtask

   // Main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_tx(1'b0, 9'h0A5);
      t_tx(1'b1, 9'h15A);
      t_tx(1'b0, 9'h1FF);
      t_b2b();
      t_rx(1'b0, 1'b0, 9'h03C, 1'b1, 1'b1);
      t_rx(1'b0, 1'b0, 9'h0C8, 1'b0, 1'b1);
      t_rx(1'b1, 1'b1, 9'h055, 1'b1, 1'b0);
      t_rx(1'b1, 1'b1, 9'h1AA, 1'b1, 1'b1);
      t_overrun();
      t_rate();
      conclude();
   end
endmodule // tb_async_serial_transceiver

//--- verilog/ast_rx_fifo.sv
// Purpose: two-entry receive FIFO holding data, ninth bit and framing error
// Assumes: single clock, writer checks full
// Notes: read data come out of a register
`timescale 1ns/1ps
`include "ast_cfg.svh"
module ast_rx_fifo #(
   parameter int W = 10,
   parameter int DEPTH = `AST_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   // Read side
   input wire logic rd_en,
   output logic [W-1:0] rd_data,
   output logic empty,
   output logic full
);
   logic [W-1:0] mem_r [DEPTH];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic do_wr;
   logic do_rd;
   assign do_wr = wr_en && (cnt_r != 2'(DEPTH));
   assign do_rd = rd_en && (cnt_r != 2'h0);
   assign empty = (cnt_r == 2'h0);
   assign full = (cnt_r == 2'(DEPTH));
   // Storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_r[wp_r] <= wr_data;
      end
   end
   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (do_wr) begin
            wp_r <= ~wp_r;
         end
         if (do_rd) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + 2'(do_wr) - 2'(do_rd);
      end
   end
   // Registered read port, head shows after each move
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_r[do_rd ? ~rp_r : rp_r];
      end
   end
endmodule // ast_rx_fifo

//--- verilog/ast_uart.sv
// Purpose: asynchronous serial transceiver, NRZ, 8 or 9 data bits
// Assumes: one clock, synchronous active-low reset, no software bus
// Notes: control bits are plain ports; shared 16x oversample tick
// Function
// - Serial output idles at mark while nothing is being sent.
// - Character is one start, eight or nine data bits, then one stop bit.
// - Start bit is space; every stop bit is mark.
// - Data and stop bits last one full bit period; the start bit runs until the sixteenth baud tick after load.
// - Data bits go and come least significant bit first.
// - Transmit and receive are independent but share format and rate.
// - No hardware parity; ninth bit is plain software data.
// - Baud generator divides system clock, 8-bit or 16-bit mode.
// - Transmit shift register loads only from holding register, never visible.
// - Overrun flagged when a character completes with the FIFO full.
// - Framing error flagged when the stop bit samples as space.
// - Nine-bit mode offers address detection on the ninth bit.
// - Transmit output drives pin and an internal logic-cell tap.
// - Pending character moves to shifter two cycles after stop bit ends.
// - Received characters move at once into a two-entry FIFO.
// - Input sampled at sixteen times baud; shifter advances once per bit.
// - Buffer-empty flag set when enabled and holding register empty.
`timescale 1ns/1ps
`include "ast_cfg.svh"
module ast_uart #(
   parameter int BRG_W = `AST_BRG_W,
   parameter logic [15:0] BRG_RST = `AST_BRG_RST
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic port_en,
   input wire logic tx_en,
   input wire logic rx_en,
   input wire logic nine_bit,
   input wire logic brg_16,
   input wire logic [BRG_W-1:0] brg_div,
   input wire logic addr_detect,
   // Transmit holding register write
   input wire logic tx_wr,
   input wire logic [8:0] tx_wdata,
   // Receive data register read
   input wire logic rx_rd,
   input wire logic ovr_clr,
   // Serial pins
   input wire logic rx_pin,
   output logic tx_or_clock_pin,
   output logic tx_to_logic_cell,
   // Status
   output logic tx_buffer_empty_flag,
   output logic tx_shift_empty,
   output logic [8:0] rx_data_reg,
   output logic rx_frame_err,
   output logic rx_avail,
   output logic rx_overrun
);
   logic [BRG_W-1:0] brg_cnt_r;
   logic tick;
   logic [BRG_W-1:0] div_eff;
   logic rx_s1_r;
   logic rx_s2_r;
   logic [2:0] hist_r;
   logic vote;
   ast_pkg::ast_tx_state_t tx_st_r;
   logic [`AST_OVS_W-1:0] tx_ph_r;
   logic [3:0] tx_bit_r;
   logic [8:0] tx_shift_reg;
   logic [8:0] tx_holding_reg;
   logic hold_full_r;
   logic tx_line_r;
   logic [1:0] tcy_r;
   ast_pkg::ast_rx_state_t rx_st_r;
   logic [`AST_OVS_W-1:0] rx_ph_r;
   logic [3:0] rx_bit_r;
   logic [8:0] rx_shift_reg;
   logic rx_prev_r;
   logic rx_done;
   logic rx_store;
   logic fifo_full;
   logic fifo_empty;
   logic [9:0] fifo_q;
   logic [3:0] nbits;
   logic bit_end_tx;
   logic tx_load;
   logic rx_mid;
   logic rx_end;

   // Shared format for both directions
   assign nbits = nine_bit ? 4'h9 : 4'h8;
   // Eight-bit mode uses only the low byte of the divisor
   assign div_eff = brg_16 ? brg_div : BRG_W'(brg_div[7:0]);

   // Baud generator: one tick per sixteenth of a bit
   always_ff @(posedge clk) begin
      if (!rst_n || !port_en) begin
         brg_cnt_r <= BRG_W'(BRG_RST);
      end else if (brg_cnt_r == '0) begin
         brg_cnt_r <= div_eff;
      end else begin
         brg_cnt_r <= brg_cnt_r - 1'b1;
      end
   end
   assign tick = port_en && (brg_cnt_r == '0);

   // Pin synchroniser; only stage two feeds logic
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rx_pin;
         rx_s2_r <= rx_s1_r;
      end
   end

   // Oversample history for the majority vote
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hist_r <= 3'h7;
      end else if (tick) begin
         hist_r <= {hist_r[1:0], rx_s2_r};
      end
   end
   assign vote = (hist_r[0] & hist_r[1]) | (hist_r[1] & hist_r[2]) | (hist_r[0] & hist_r[2]);

   // Holding register: software side of the transmitter
   assign bit_end_tx = tick && (tx_ph_r == 4'(`AST_OVS - 1));
   assign tx_load = hold_full_r && (tx_st_r == ast_pkg::TX_IDLE) && (tcy_r == 2'h0) && tx_en;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_holding_reg <= 9'h000;
         hold_full_r <= 1'b0;
      end else if (tx_wr && (!hold_full_r || tx_load)) begin
         tx_holding_reg <= nine_bit ? tx_wdata : {1'b0, tx_wdata[7:0]};
         hold_full_r <= 1'b1;
      end else if (tx_load) begin
         hold_full_r <= 1'b0;
      end
   end

   // Gap of one instruction cycle after the stop bit before reload
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tcy_r <= 2'h0;
      end else if (tx_st_r == ast_pkg::TX_STOP && bit_end_tx) begin
         tcy_r <= 2'(`AST_TCY_CYC);
      end else if (tcy_r != 2'h0) begin
         tcy_r <= tcy_r - 2'h1;
      end
   end

   // Transmit state machine
   always_ff @(posedge clk) begin
      if (!rst_n || !tx_en) begin
         tx_st_r <= ast_pkg::TX_IDLE;
         tx_ph_r <= '0;
         tx_bit_r <= 4'h0;
         tx_shift_reg <= 9'h000;
      end else begin
         case (tx_st_r)
            ast_pkg::TX_IDLE: begin
               tx_ph_r <= '0;
               if (tx_load) begin
                  tx_shift_reg <= tx_holding_reg;
                  tx_bit_r <= 4'h0;
                  tx_st_r <= ast_pkg::TX_START;
               end
            end
            ast_pkg::TX_START: begin
               if (tick) begin
                  tx_ph_r <= tx_ph_r + 1'b1;
               end
               if (bit_end_tx) begin
                  tx_st_r <= ast_pkg::TX_DATA;
               end
            end
            ast_pkg::TX_DATA: begin
               if (tick) begin
                  tx_ph_r <= tx_ph_r + 1'b1;
               end
               if (bit_end_tx) begin
                  tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                  tx_bit_r <= tx_bit_r + 4'h1;
                  if (tx_bit_r == nbits - 4'h1) begin
                     tx_st_r <= ast_pkg::TX_STOP;
                  end
               end
            end
            ast_pkg::TX_STOP: begin
               if (tick) begin
                  tx_ph_r <= tx_ph_r + 1'b1;
               end
               if (bit_end_tx) begin
                  tx_st_r <= ast_pkg::TX_IDLE;
               end
            end
            default: begin
               tx_st_r <= ast_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // Line level, registered to keep the pin glitch free
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_line_r <= 1'b1;
      end else begin
         case (tx_st_r)
            ast_pkg::TX_START: tx_line_r <= 1'b0;
            ast_pkg::TX_DATA: tx_line_r <= tx_shift_reg[0];
            default: tx_line_r <= 1'b1;
         endcase
      end
   end

   // Pin and internal tap carry the same bit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_or_clock_pin <= 1'b1;
         tx_to_logic_cell <= 1'b1;
      end else begin
         tx_or_clock_pin <= tx_line_r;
         tx_to_logic_cell <= tx_line_r;
      end
   end

   // Transmit status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_buffer_empty_flag <= 1'b0;
         tx_shift_empty <= 1'b1;
      end else begin
         tx_buffer_empty_flag <= tx_en && !hold_full_r;
         tx_shift_empty <= (tx_st_r == ast_pkg::TX_IDLE);
      end
   end

   // Receive state machine; centre sample at phase eight
   assign rx_mid = tick && (rx_ph_r == 4'(`AST_OVS_MID));
   assign rx_end = tick && (rx_ph_r == 4'(`AST_OVS - 1));
   always_ff @(posedge clk) begin
      if (!rst_n || !rx_en || !port_en) begin
         rx_st_r <= ast_pkg::RX_IDLE;
         rx_ph_r <= '0;
         rx_bit_r <= 4'h0;
         rx_shift_reg <= 9'h000;
         rx_prev_r <= 1'b1;
      end else begin
         if (tick) begin
            rx_prev_r <= rx_s2_r;
         end
         case (rx_st_r)
            ast_pkg::RX_IDLE: begin
               rx_ph_r <= '0;
               if (tick && rx_prev_r && !rx_s2_r) begin
                  rx_st_r <= ast_pkg::RX_START;
                  rx_ph_r <= 4'h1;
               end
            end
            ast_pkg::RX_START: begin
               if (tick) begin
                  rx_ph_r <= rx_ph_r + 1'b1;
               end
               if (rx_mid && vote) begin
                  rx_st_r <= ast_pkg::RX_IDLE;
               end else if (rx_end) begin
                  rx_bit_r <= 4'h0;
                  rx_st_r <= ast_pkg::RX_DATA;
               end
            end
            ast_pkg::RX_DATA: begin
               if (tick) begin
                  rx_ph_r <= rx_ph_r + 1'b1;
               end
               if (rx_mid) begin
                  // Shift in at the top so the first bit ends at bit zero
                  if (nine_bit) begin
                     rx_shift_reg <= {vote, rx_shift_reg[8:1]};
                  end else begin
                     rx_shift_reg <= {1'b0, vote, rx_shift_reg[7:1]};
                  end
                  rx_bit_r <= rx_bit_r + 4'h1;
               end
               if (rx_end && rx_bit_r == nbits) begin
                  rx_st_r <= ast_pkg::RX_STOP;
               end
            end
            ast_pkg::RX_STOP: begin
               if (tick) begin
                  rx_ph_r <= rx_ph_r + 1'b1;
               end
               // Leave at centre so the next start edge is not missed
               if (rx_mid) begin
                  rx_st_r <= ast_pkg::RX_IDLE;
               end
            end
            default: begin
               rx_st_r <= ast_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // Character done at stop-bit centre; address filter drops data frames
   assign rx_done = (rx_st_r == ast_pkg::RX_STOP) && rx_mid;
   assign rx_store = rx_done && !(nine_bit && addr_detect && !rx_shift_reg[8]);

   ast_rx_fifo #(
      .W(10),
      .DEPTH(`AST_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(rx_store && !fifo_full),
      .wr_data({!vote, rx_shift_reg}),
      .rd_en(rx_rd),
      .rd_data(fifo_q),
      .empty(fifo_empty),
      .full(fifo_full)
   );

   // Overrun is sticky; a new event beats the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_overrun <= 1'b0;
      end else if (rx_store && fifo_full) begin
         rx_overrun <= 1'b1;
      end else if (ovr_clr) begin
         rx_overrun <= 1'b0;
      end
   end

   // Receive data register view of the FIFO head
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_data_reg <= 9'h000;
         rx_frame_err <= 1'b0;
         rx_avail <= 1'b0;
      end else begin
         rx_data_reg <= fifo_q[8:0];
         rx_frame_err <= fifo_q[9] && !fifo_empty;
         rx_avail <= !fifo_empty;
      end
   end

   a_tx_idle_mark: assert property (@(posedge clk) disable iff (!rst_n)
      $past(tx_st_r) == ast_pkg::TX_IDLE && $past(tx_st_r, 2) == ast_pkg::TX_IDLE |-> tx_or_clock_pin)
      else $error("line not at mark while idle");
   a_tx_start_space: assert property (@(posedge clk) disable iff (!rst_n)
      $past(tx_st_r) == ast_pkg::TX_START |-> !tx_line_r)
      else $error("start bit not space");
   a_tx_stop_mark: assert property (@(posedge clk) disable iff (!rst_n)
      $past(tx_st_r) == ast_pkg::TX_STOP |-> tx_line_r)
      else $error("stop bit not mark");
   a_tap_matches: assert property (@(posedge clk) disable iff (!rst_n)
      tx_or_clock_pin == tx_to_logic_cell)
      else $error("tap differs from pin");
   a_tbe_flag: assert property (@(posedge clk) disable iff (!rst_n)
      tx_buffer_empty_flag == $past(tx_en && !hold_full_r))
      else $error("buffer empty flag wrong");
   a_ovr_set: assert property (@(posedge clk) disable iff (!rst_n)
      rx_store && fifo_full |=> rx_overrun)
      else $error("overrun not flagged");
   a_fifo_push: assert property (@(posedge clk) disable iff (!rst_n)
      rx_store && !fifo_full |=> !fifo_empty)
      else $error("received char not stored");
   a_tx_bits_count: assert property (@(posedge clk) disable iff (!rst_n || !tx_en)
      tx_st_r == ast_pkg::TX_DATA && $past(tx_st_r) == ast_pkg::TX_DATA |-> tx_bit_r < nbits)
      else $error("too many data bits");
   a_tx_reload_gap: assert property (@(posedge clk) disable iff (!rst_n)
      tx_load |-> tcy_r == 2'h0 && $past(tx_st_r) == ast_pkg::TX_IDLE)
      else $error("reload before gap");
   a_addr_filter: assert property (@(posedge clk) disable iff (!rst_n)
      rx_done && nine_bit && addr_detect && !rx_shift_reg[8] |-> !rx_store)
      else $error("data frame passed address filter");
endmodule // ast_uart
